/* File: core/sys_pm_pin_control.sv */
`timescale 1ns/1ns
`default_nettype none
module sys_pm_pin_control
	import sys_pm_pkg::*;
#(
	parameter logic [22:0] WAKE_PULSE_CYCLES = WAKE_PULSE_CYC
) (
	input  wire logic                 REF_CLK,
	input  wire logic                 RST,
	input  wire logic                 POWER_UP_RESET_N,
	input  wire logic                 BUS_RESET_N,
	input  wire logic                 DETACH_N,
	input  wire logic [HOST_W-1:0]    HOST_OUT_D,
	input  wire logic [HOST_W-1:0]    HOST_OUT_EN,
	input  wire logic [HOST_W-1:0]    HOST_PIN_IN,
	output logic      [HOST_W-1:0]    HOST_PIN_OUT,
	output logic      [HOST_W-1:0]    HOST_PIN_OE,
	output logic      [HOST_W-1:0]    HOST_IN_Q,
	output logic                      BUS_IN_RESET,
	input  wire logic                 CLOCK_PAUSE_IN,
	output logic                      CLOCK_PAUSE_OUT,
	output logic                      CLOCK_PAUSE_OE,
	input  wire logic                 CLOCK_NEEDED,
	output logic                      CLOCK_STOP_OK,
	input  wire logic                 CARDBUS_MODE,
	input  wire logic                 PM_EVENT_SET,
	input  wire logic                 PM_EVENT_CLEAR,
	input  wire logic                 WAKE_FRAME_SEEN,
	output logic                      PM_EVENT_N_OUT,
	output logic                      PM_EVENT_N_OE,
	output logic                      CARD_STATUS_CHANGE_OR_WAKE_PULSE,
	input  wire logic                 FLASH_REQ,
	input  wire logic [FL_ADDR_W-1:0] FLASH_ADDR,
	input  wire logic                 FLASH_WRITE,
	input  wire logic [FL_DATA_W-1:0] FLASH_WDATA,
	output logic                      FLASH_DONE,
	output logic      [FL_DATA_W-1:0] FLASH_RDATA,
	input  wire logic                 ROM_REQ,
	input  wire logic [ROM_W-1:0]     ROM_TX,
	input  wire logic [ROM_LEN_W-1:0] ROM_LEN,
	output logic                      ROM_DONE,
	output logic      [ROM_W-1:0]     ROM_RDATA,
	output logic                      MEM_BUSY,
	output logic                      FLASH_ADDR16_OR_CLOCK_OUT,
	output logic                      FLASH_ADDR15_OR_ROM_CLOCK,
	input  wire logic                 FLASH_ADDR14_OR_ROM_SERIAL_IN_IN,
	output logic                      FLASH_ADDR14_OR_ROM_SERIAL_IN_OUT,
	output logic                      FLASH_ADDR14_OR_ROM_SERIAL_IN_OE,
	output logic                      FLASH_ADDR13_OR_ROM_SERIAL_OUT,
	input  wire logic                 CLOCK_OUT_STRAP_IN,
	output logic                      CLOCK_OUT_STRAP_OUT,
	output logic                      CLOCK_OUT_STRAP_OE,
	output logic      [11:0]          FLASH_ADDR_REST,
	input  wire logic [FL_DATA_W-1:0] FLASH_DATA_BUS_IN,
	output logic      [FL_DATA_W-1:0] FLASH_DATA_BUS_OUT,
	output logic      [FL_DATA_W-1:0] FLASH_DATA_BUS_OE,
	output logic                      FLASH_SELECT_N,
	output logic                      FLASH_WRITE_N,
	output logic                      ROM_CHIP_SELECT
);
	////////////////////////////////////////////////////////////////////////////
	// reset and isolation decode
	wire rst_all;
	wire bus_quiet;
	wire bus_rst;

	assign rst_all   = RST || !POWER_UP_RESET_N;
	// while detached even the bus reset is not looked at
	assign bus_rst   = DETACH_N && !BUS_RESET_N;
	assign bus_quiet = !DETACH_N || !BUS_RESET_N;

	////////////////////////////////////////////////////////////////////////////
	// host bus pins
	logic [HOST_W-1:0] host_out_q;
	logic [HOST_W-1:0] host_oe_q;
	logic [HOST_W-1:0] host_in_q;
	logic              bus_in_reset_q;

	always_ff @(posedge REF_CLK) begin
		if (rst_all || bus_rst) begin
			host_out_q <= '0;
			host_oe_q  <= '0;
			host_in_q  <= '0;
		end else if (DETACH_N) begin
			host_out_q <= HOST_OUT_D;
			host_oe_q  <= HOST_OUT_EN;
			host_in_q  <= HOST_PIN_IN;
		end else begin
			host_oe_q  <= '0;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (rst_all) begin
			bus_in_reset_q <= 1'b1;
		end else begin
			bus_in_reset_q <= bus_rst;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// clock-pause handshake
	// counts on the host keeping the bus clock at 16 MHz or more
	logic [1:0] hold_q;
	logic       pause_oe_q;
	logic       stop_ok_q;
	wire        pause_seen;
	wire        want_clock;

	// a detached device samples nothing, so it never objects
	assign pause_seen = DETACH_N && CLOCK_PAUSE_IN;
	assign want_clock = pause_seen && CLOCK_NEEDED && (hold_q == 2'h0);

	always_ff @(posedge REF_CLK) begin
		if (rst_all || bus_quiet) begin
			hold_q     <= 2'h0;
			pause_oe_q <= 1'b0;
			stop_ok_q  <= 1'b0;
		end else begin
			if (want_clock) begin
				hold_q <= CLKRUN_HOLD_CYC;
			end else if (hold_q != 2'h0) begin
				hold_q <= hold_q - 2'h1;
			end
			pause_oe_q <= want_clock || (hold_q > 2'h1);
			stop_ok_q  <= pause_seen && !CLOCK_NEEDED && (hold_q == 2'h0);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// power management event and wake
	logic        pm_flag_q;
	logic [22:0] wake_cnt_q;
	logic        pme_oe_q;
	logic        status_q;
	wire         pm_flag_d;
	wire  [22:0] wake_cnt_d;

	// a new event in the clearing cycle is kept
	assign pm_flag_d  = PM_EVENT_SET || (pm_flag_q && !PM_EVENT_CLEAR);
	// a second wake frame during a pulse does not stretch it
	assign wake_cnt_d = (WAKE_FRAME_SEEN && !CARDBUS_MODE && wake_cnt_q == 23'h000000)
		? WAKE_PULSE_CYCLES
		: (wake_cnt_q != 23'h000000 ? wake_cnt_q - 23'h000001 : 23'h000000);

	// these pins stay alive through detach and bus reset
	always_ff @(posedge REF_CLK) begin
		if (rst_all) begin
			pm_flag_q  <= 1'b0;
			wake_cnt_q <= 23'h000000;
			pme_oe_q   <= 1'b0;
			status_q   <= 1'b0;
		end else begin
			pm_flag_q  <= pm_flag_d;
			wake_cnt_q <= wake_cnt_d;
			pme_oe_q   <= pm_flag_d && !CARDBUS_MODE;
			status_q   <= CARDBUS_MODE ? pm_flag_d
				: (wake_cnt_d != 23'h000000);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// strap and 25 MHz clock
	logic       strap_q;
	logic       strap_oe_q;
	logic [2:0] div_q;
	logic       clk25_q;

	// loaded only while in reset: the pin level then is the value to be kept
	always_ff @(posedge REF_CLK) begin
		if (rst_all) begin
			strap_q <= CLOCK_OUT_STRAP_IN;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (rst_all) begin
			strap_oe_q <= 1'b0;
			div_q      <= 3'h0;
			clk25_q    <= 1'b0;
		end else begin
			strap_oe_q <= 1'b1;
			div_q      <= (div_q == CLK25_DIV - 3'h1) ? 3'h0 : div_q + 3'h1;
			// 2 of 5 cycles high: the nearest to half duty at this ratio
			clk25_q    <= (div_q < CLK25_HIGH);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// access arbitration for the shared pins
	mem_link_if lnk ();

	owner_t owner_q;
	owner_t owner_d;
	logic   busy_q;
	wire    own_fl;
	wire    own_rom;
	wire    take_fl;
	wire    take_rom;

	// flash wins a tie; requests while busy are dropped
	assign take_fl  = (owner_q == OWN_IDLE) && FLASH_REQ;
	assign take_rom = (owner_q == OWN_IDLE) && ROM_REQ && !FLASH_REQ;
	assign own_fl   = (owner_q == OWN_FLASH);
	assign own_rom  = (owner_q == OWN_ROM);

	always_comb begin
		owner_d = owner_q;
		unique case (owner_q)
			OWN_IDLE: begin
				if (take_fl) begin
					owner_d = OWN_FLASH;
				end else if (take_rom) begin
					owner_d = OWN_ROM;
				end
			end
			OWN_FLASH: begin
				if (lnk.fl_done) begin
					owner_d = OWN_IDLE;
				end
			end
			OWN_ROM: begin
				if (lnk.rom_done) begin
					owner_d = OWN_IDLE;
				end
			end
			default: begin
				owner_d = OWN_IDLE;
			end
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (rst_all) begin
			owner_q <= OWN_IDLE;
			busy_q  <= 1'b0;
		end else begin
			owner_q <= owner_d;
			busy_q  <= (owner_d != OWN_IDLE);
		end
	end

	assign lnk.rom_start  = take_rom;
	assign lnk.rom_tx     = ROM_TX;
	assign lnk.rom_len    = ROM_LEN;
	assign lnk.rom_do     = FLASH_ADDR14_OR_ROM_SERIAL_IN_IN;
	assign lnk.fl_start   = take_fl;
	assign lnk.fl_addr    = FLASH_ADDR;
	assign lnk.fl_wr      = FLASH_WRITE;
	assign lnk.fl_wdata   = FLASH_WDATA;
	assign lnk.fl_data_in = FLASH_DATA_BUS_IN;

	rom_serial u_rom (
		.clk (REF_CLK),
		.rst (rst_all),
		.lnk (lnk.rom_eng)
	);

	flash_access u_flash (
		.clk (REF_CLK),
		.rst (rst_all),
		.lnk (lnk.fl_eng)
	);

	////////////////////////////////////////////////////////////////////////////
	// shared pin drive, all registered
	logic [FL_ADDR_W-1:0] a_q;
	logic [FL_DATA_W-1:0] d_q;
	logic                 d_oe_q;
	logic                 a14_oe_q;
	logic                 sel_n_q;
	logic                 we_n_q;
	logic                 cs_q;
	logic                 fl_done_q;
	logic                 rom_done_q;
	logic [FL_DATA_W-1:0] fl_rdata_q;
	logic [ROM_W-1:0]     rom_rdata_q;
	wire  [FL_ADDR_W-1:0] a_d;

	assign a_d = own_fl ? lnk.fl_pin_addr : '0;

	always_ff @(posedge REF_CLK) begin
		if (rst_all) begin
			a_q         <= '0;
			d_q         <= '0;
			d_oe_q      <= 1'b0;
			a14_oe_q    <= 1'b0;
			sel_n_q     <= SEL_N_RST;
			we_n_q      <= WE_N_RST;
			cs_q        <= 1'b0;
			fl_done_q   <= 1'b0;
			rom_done_q  <= 1'b0;
			fl_rdata_q  <= '0;
			rom_rdata_q <= '0;
		end else begin
			a_q[A16_BIT]  <= strap_q ? clk25_q : a_d[A16_BIT];
			a_q[A15_BIT]  <= own_rom ? lnk.rom_sk : a_d[A15_BIT];
			a_q[A14_BIT]  <= a_d[A14_BIT];
			a_q[A13_BIT]  <= own_rom ? lnk.rom_di : a_d[A13_BIT];
			a_q[12:8]     <= a_d[12:8];
			a_q[A7_BIT]   <= a_d[A7_BIT];
			a_q[6:0]      <= a_d[6:0];
			a14_oe_q      <= own_fl;
			d_q           <= lnk.fl_pin_data;
			d_oe_q        <= own_fl && lnk.fl_data_oe;
			sel_n_q       <= !own_fl || lnk.fl_sel_n;
			we_n_q        <= !own_fl || lnk.fl_we_n;
			cs_q          <= own_rom && lnk.rom_cs;
			fl_done_q     <= lnk.fl_done;
			rom_done_q    <= lnk.rom_done;
			if (lnk.fl_done) begin
				fl_rdata_q <= lnk.fl_rdata;
			end
			if (lnk.rom_done) begin
				rom_rdata_q <= lnk.rom_rx;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign HOST_PIN_OUT    = host_out_q;
	assign HOST_PIN_OE     = host_oe_q;
	assign HOST_IN_Q       = host_in_q;
	assign BUS_IN_RESET    = bus_in_reset_q;
	// open drain: only ever pulls low
	assign CLOCK_PAUSE_OUT = 1'b0 & pause_oe_q;
	assign CLOCK_PAUSE_OE  = pause_oe_q;
	assign CLOCK_STOP_OK   = stop_ok_q;
	assign PM_EVENT_N_OUT  = 1'b0 & pme_oe_q;
	assign PM_EVENT_N_OE   = pme_oe_q;
	assign CARD_STATUS_CHANGE_OR_WAKE_PULSE = status_q;
	assign FLASH_DONE      = fl_done_q;
	assign FLASH_RDATA     = fl_rdata_q;
	assign ROM_DONE        = rom_done_q;
	assign ROM_RDATA       = rom_rdata_q;
	assign MEM_BUSY        = busy_q;
	assign FLASH_ADDR16_OR_CLOCK_OUT         = a_q[A16_BIT];
	assign FLASH_ADDR15_OR_ROM_CLOCK         = a_q[A15_BIT];
	assign FLASH_ADDR14_OR_ROM_SERIAL_IN_OUT = a_q[A14_BIT];
	assign FLASH_ADDR14_OR_ROM_SERIAL_IN_OE  = a14_oe_q;
	assign FLASH_ADDR13_OR_ROM_SERIAL_OUT    = a_q[A13_BIT];
	assign CLOCK_OUT_STRAP_OUT = a_q[A7_BIT];
	assign CLOCK_OUT_STRAP_OE  = strap_oe_q;
	assign FLASH_ADDR_REST     = {a_q[12:8], a_q[6:0]};
	assign FLASH_DATA_BUS_OUT  = d_q;
	assign FLASH_DATA_BUS_OE   = {FL_DATA_W{d_oe_q}};
	assign FLASH_SELECT_N      = sel_n_q;
	assign FLASH_WRITE_N       = we_n_q;
	assign ROM_CHIP_SELECT     = cs_q;
endmodule // sys_pm_pin_control
`default_nettype wire

/* File: core/sys_pm_pkg.sv */
package sys_pm_pkg;
	// clock and time base
	localparam int CLK_MHZ    = 125;
	localparam int REF_CLK_NS = 1000 / CLK_MHZ;
	// wake pulse length, about 52 ms
	localparam int          WAKE_PULSE_MS  = 52;
	localparam logic [22:0] WAKE_PULSE_CYC = 23'(WAKE_PULSE_MS * 1000 * CLK_MHZ);
	// serial rom shift clock half period, least time
	localparam int          ROM_SK_HALF_NS  = 1000;
	localparam logic [7:0]  ROM_SK_HALF_CYC =
		8'((ROM_SK_HALF_NS + REF_CLK_NS - 1) / REF_CLK_NS);
	// flash strobe length, least time
	localparam int          FLASH_ACCESS_NS  = 150;
	localparam logic [4:0]  FLASH_ACCESS_CYC =
		5'((FLASH_ACCESS_NS + REF_CLK_NS - 1) / REF_CLK_NS);
	// 25 MHz output from the 125 MHz clock
	localparam int          CLK25_MHZ  = 25;
	localparam logic [2:0]  CLK25_DIV  = 3'(CLK_MHZ / CLK25_MHZ);
	localparam logic [2:0]  CLK25_HIGH = 3'(CLK_MHZ / (2 * CLK25_MHZ));
	// cycles the clock-pause line is pulled low to refuse or restart
	localparam logic [1:0]  CLKRUN_HOLD_CYC = 2'h2;
	// widths
	localparam int HOST_W     = 8;
	localparam int ROM_W      = 16;
	localparam int ROM_LEN_W  = 5;
	localparam int FL_ADDR_W  = 17;
	localparam int FL_DATA_W  = 8;
	// bit positions of the shared address pins
	localparam int A16_BIT = 16;
	localparam int A15_BIT = 15;
	localparam int A14_BIT = 14;
	localparam int A13_BIT = 13;
	localparam int A7_BIT  = 7;
	// reset values
	localparam logic SEL_N_RST = 1'b1;
	localparam logic WE_N_RST  = 1'b1;

	typedef enum logic [1:0] {
		OWN_IDLE  = 2'b00,
		OWN_FLASH = 2'b01,
		OWN_ROM   = 2'b10
	} owner_t;

	typedef enum logic [1:0] {
		ROM_IDLE = 2'b00,
		ROM_LOW  = 2'b01,
		ROM_HIGH = 2'b10
	} rom_state_t;

	typedef enum logic {
		FL_IDLE = 1'b0,
		FL_BUSY = 1'b1
	} fl_state_t;
endpackage

/* File: core/mem_link_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface mem_link_if;
	import sys_pm_pkg::*;
	logic                 rom_start;
	logic [ROM_W-1:0]     rom_tx;
	logic [ROM_LEN_W-1:0] rom_len;
	logic                 rom_done;
	logic [ROM_W-1:0]     rom_rx;
	logic                 rom_sk;
	logic                 rom_di;
	logic                 rom_do;
	logic                 rom_cs;
	logic                 fl_start;
	logic [FL_ADDR_W-1:0] fl_addr;
	logic                 fl_wr;
	logic [FL_DATA_W-1:0] fl_wdata;
	logic                 fl_done;
	logic [FL_DATA_W-1:0] fl_rdata;
	logic [FL_ADDR_W-1:0] fl_pin_addr;
	logic [FL_DATA_W-1:0] fl_pin_data;
	logic                 fl_data_oe;
	logic [FL_DATA_W-1:0] fl_data_in;
	logic                 fl_sel_n;
	logic                 fl_we_n;

	modport rom_eng (input rom_start, rom_tx, rom_len, rom_do,
		output rom_done, rom_rx, rom_sk, rom_di, rom_cs);
	modport fl_eng (input fl_start, fl_addr, fl_wr, fl_wdata, fl_data_in,
		output fl_done, fl_rdata, fl_pin_addr, fl_pin_data, fl_data_oe,
		fl_sel_n, fl_we_n);
	modport ctl (output rom_start, rom_tx, rom_len, rom_do,
		fl_start, fl_addr, fl_wr, fl_wdata, fl_data_in,
		input rom_done, rom_rx, rom_sk, rom_di, rom_cs,
		fl_done, fl_rdata, fl_pin_addr, fl_pin_data, fl_data_oe,
		fl_sel_n, fl_we_n);
endinterface // mem_link_if
`default_nettype wire

/* File: core/rom_serial.sv */
`timescale 1ns/1ns
`default_nettype none
module rom_serial
	import sys_pm_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	mem_link_if.rom_eng lnk
);
	rom_state_t           state_q;
	logic [7:0]           tick_q;
	logic [ROM_LEN_W-1:0] left_q;
	logic [ROM_W-1:0]     sh_q;
	logic                 done_q;
	wire                  tick_end;
	wire                  last_bit;

	assign tick_end = (tick_q == ROM_SK_HALF_CYC - 8'h01);
	assign last_bit = (left_q == ROM_LEN_W'(1));

	// one shift register: command out of the top, read data in at the bottom
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= ROM_IDLE;
			tick_q  <= 8'h00;
			left_q  <= '0;
			sh_q    <= '0;
			done_q  <= 1'b0;
		end else begin
			done_q <= 1'b0;
			tick_q <= tick_end ? 8'h00 : tick_q + 8'h01;
			unique case (state_q)
				ROM_IDLE: begin
					tick_q <= 8'h00;
					if (lnk.rom_start) begin
						state_q <= ROM_LOW;
						sh_q    <= lnk.rom_tx;
						left_q  <= lnk.rom_len;
					end
				end
				ROM_LOW: begin
					if (tick_end) begin
						state_q <= ROM_HIGH;
					end
				end
				ROM_HIGH: begin
					// sample late in the high phase, data out moves on the fall
					if (tick_end) begin
						sh_q    <= {sh_q[ROM_W-2:0], lnk.rom_do};
						left_q  <= left_q - ROM_LEN_W'(1);
						state_q <= last_bit ? ROM_IDLE : ROM_LOW;
						done_q  <= last_bit;
					end
				end
			endcase
		end
	end

	assign lnk.rom_sk   = (state_q == ROM_HIGH);
	assign lnk.rom_di   = sh_q[ROM_W-1];
	assign lnk.rom_cs   = (state_q != ROM_IDLE);
	assign lnk.rom_done = done_q;
	assign lnk.rom_rx   = sh_q;
endmodule // rom_serial
`default_nettype wire

/* File: core/flash_access.sv */
`timescale 1ns/1ns
`default_nettype none
module flash_access
	import sys_pm_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	mem_link_if.fl_eng lnk
);
	fl_state_t            state_q;
	logic [4:0]           cnt_q;
	logic [FL_ADDR_W-1:0] addr_q;
	logic [FL_DATA_W-1:0] wdata_q;
	logic [FL_DATA_W-1:0] rdata_q;
	logic                 wr_q;
	logic                 done_q;
	wire                  cnt_end;

	assign cnt_end = (cnt_q == FLASH_ACCESS_CYC - 5'h01);

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= FL_IDLE;
			cnt_q   <= 5'h00;
			addr_q  <= '0;
			wdata_q <= '0;
			rdata_q <= '0;
			wr_q    <= 1'b0;
			done_q  <= 1'b0;
		end else begin
			done_q <= 1'b0;
			unique case (state_q)
				FL_IDLE: begin
					cnt_q <= 5'h00;
					if (lnk.fl_start) begin
						state_q <= FL_BUSY;
						addr_q  <= lnk.fl_addr;
						wdata_q <= lnk.fl_wdata;
						wr_q    <= lnk.fl_wr;
					end
				end
				FL_BUSY: begin
					cnt_q <= cnt_q + 5'h01;
					if (cnt_end) begin
						// read data taken at the end of the strobe
						rdata_q <= lnk.fl_data_in;
						state_q <= FL_IDLE;
						done_q  <= 1'b1;
					end
				end
			endcase
		end
	end

	assign lnk.fl_pin_addr = addr_q;
	assign lnk.fl_pin_data = wdata_q;
	assign lnk.fl_data_oe  = (state_q == FL_BUSY) && wr_q;
	assign lnk.fl_sel_n    = (state_q != FL_BUSY);
	assign lnk.fl_we_n     = !((state_q == FL_BUSY) && wr_q);
	assign lnk.fl_done     = done_q;
	assign lnk.fl_rdata    = rdata_q;
endmodule // flash_access
`default_nettype wire

/* File: test/sys_pm_pin_control_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module sys_pm_sva
	import sys_pm_pkg::*;
#(
	parameter logic [22:0] WAKE_PULSE_CYCLES = WAKE_PULSE_CYC
) (
	input wire logic              REF_CLK,
	input wire logic              RST,
	input wire logic              POWER_UP_RESET_N,
	input wire logic              BUS_RESET_N,
	input wire logic              DETACH_N,
	input wire logic [HOST_W-1:0] HOST_PIN_OE,
	input wire logic [HOST_W-1:0] HOST_IN_Q,
	input wire logic              CLOCK_PAUSE_IN,
	input wire logic              CLOCK_PAUSE_OE,
	input wire logic              CLOCK_NEEDED,
	input wire logic              CARDBUS_MODE,
	input wire logic              PM_EVENT_SET,
	input wire logic              PM_EVENT_N_OE,
	input wire logic              CARD_STATUS_CHANGE_OR_WAKE_PULSE,
	input wire logic              FLASH_REQ,
	input wire logic              FLASH_DONE,
	input wire logic              ROM_DONE,
	input wire logic              MEM_BUSY,
	input wire logic              FLASH_ADDR16_OR_CLOCK_OUT,
	input wire logic              FLASH_ADDR14_OR_ROM_SERIAL_IN_OE,
	input wire logic              CLOCK_OUT_STRAP_IN,
	input wire logic              CLOCK_OUT_STRAP_OE,
	input wire logic              FLASH_SELECT_N,
	input wire logic              ROM_CHIP_SELECT
);
	wire logic   rst_any = RST | ~POWER_UP_RESET_N;
	logic        strap_q;
	logic [22:0] hi_q;
	// strap copy follows the design: last reset edge wins
	always_ff @(posedge REF_CLK) if (rst_any) strap_q <= CLOCK_OUT_STRAP_IN;
	always_ff @(posedge REF_CLK)
		hi_q <= (rst_any | ~CARD_STATUS_CHANGE_OR_WAKE_PULSE) ? '0 : hi_q + 23'h1;
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (rst_any);
	////////////////////////////////////////////////////////////////
	a_bus_float: assert property (!BUS_RESET_N && DETACH_N |=> HOST_PIN_OE == '0)
		else $error("bus outputs driven under bus reset");
	a_detach_hold: assert property (!DETACH_N |=> HOST_PIN_OE == '0 && $stable(HOST_IN_Q))
		else $error("bus pins active while detached");
	a_wake_len: assert property ($fell(CARD_STATUS_CHANGE_OR_WAKE_PULSE) && !CARDBUS_MODE
		|-> hi_q == WAKE_PULSE_CYCLES) else $error("wake pulse length wrong");
	a_event_set: assert property (PM_EVENT_SET && !CARDBUS_MODE |=> PM_EVENT_N_OE)
		else $error("event pin not pulled");
	a_pause_hold: assert property (CLOCK_PAUSE_IN && CLOCK_NEEDED && !CLOCK_PAUSE_OE
		&& DETACH_N && BUS_RESET_N |=> CLOCK_PAUSE_OE [*2] ##1 !CLOCK_PAUSE_OE)
		else $error("clock pause hold wrong");
	a_clk25_shape: assert property ($rose(FLASH_ADDR16_OR_CLOCK_OUT) && strap_q |=>
		FLASH_ADDR16_OR_CLOCK_OUT ##1 !FLASH_ADDR16_OR_CLOCK_OUT [*3] ##1 FLASH_ADDR16_OR_CLOCK_OUT)
		else $error("25 MHz output shape wrong");
	a_strap_drive: assert property (!rst_any |=> CLOCK_OUT_STRAP_OE)
		else $error("strap pin not driven after reset");
	a_rom_excl: assert property (ROM_CHIP_SELECT |-> FLASH_SELECT_N
		&& !FLASH_ADDR14_OR_ROM_SERIAL_IN_OE) else $error("rom and flash overlap");
	a_flash_time: assert property (FLASH_REQ && !MEM_BUSY && !ROM_CHIP_SELECT
		|-> ##21 FLASH_DONE) else $error("flash done late");
	c_flash: cover property (FLASH_DONE);
	c_rom: cover property (ROM_DONE);
	c_wake: cover property ($fell(CARD_STATUS_CHANGE_OR_WAKE_PULSE) && !CARDBUS_MODE);
endmodule // sys_pm_sva
bind sys_pm_pin_control sys_pm_sva #(.WAKE_PULSE_CYCLES(WAKE_PULSE_CYCLES)) chk_i (.*);
`default_nettype wire

/* File: test/rom_model.sv */
`timescale 1ns/1ns
`default_nettype none
module rom_model #(
	parameter logic [15:0] WORD = 16'h9e35
) (
	input wire logic  cs,
	input wire logic  sk,
	input wire logic  si,
	output logic      so,
	output logic [15:0] rx
);
	logic [3:0] idx;
	initial so = 1'b0;
	always @(posedge cs) idx = 4'hf;
	// released line has no pull: show the inverse, never a stale bit
	always @(negedge cs) so = ~so;
	always @(posedge sk) if (cs) begin
		so <= WORD[idx];
		idx <= idx - 4'h1;
		rx <= {rx[14:0], si};
	end
endmodule // rom_model
`default_nettype wire

/* File: test/sys_pm_pin_control_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module sys_pm_pin_control_tb;
	localparam logic [22:0] WAKE = 23'h14;
	localparam logic [15:0] ROM_WORD = 16'h9e35;
	logic REF_CLK, RST, POWER_UP_RESET_N, BUS_RESET_N, DETACH_N, CLOCK_PAUSE_IN, CLOCK_NEEDED;
	logic CARDBUS_MODE, PM_EVENT_SET, PM_EVENT_CLEAR, WAKE_FRAME_SEEN, FLASH_REQ, FLASH_WRITE;
	logic ROM_REQ, strap_up, BUS_IN_RESET, CLOCK_PAUSE_OUT, CLOCK_PAUSE_OE, CLOCK_STOP_OK;
	logic [7:0] HOST_OUT_D, HOST_OUT_EN, HOST_PIN_IN, FLASH_WDATA, HOST_PIN_OUT, HOST_PIN_OE;
	logic [7:0] HOST_IN_Q, FLASH_RDATA, FLASH_DATA_BUS_OUT, FLASH_DATA_BUS_OE;
	logic [16:0] FLASH_ADDR;
	logic [15:0] ROM_TX, ROM_RDATA, rom_rx;
	logic [11:0] FLASH_ADDR_REST;
	logic [4:0] ROM_LEN;
	logic PM_EVENT_N_OUT, PM_EVENT_N_OE, CARD_STATUS_CHANGE_OR_WAKE_PULSE, FLASH_DONE, ROM_DONE;
	logic MEM_BUSY, FLASH_ADDR16_OR_CLOCK_OUT, FLASH_ADDR15_OR_ROM_CLOCK, rom_so;
	logic FLASH_ADDR14_OR_ROM_SERIAL_IN_OUT, FLASH_ADDR14_OR_ROM_SERIAL_IN_OE;
	logic FLASH_ADDR13_OR_ROM_SERIAL_OUT, CLOCK_OUT_STRAP_OUT, CLOCK_OUT_STRAP_OE;
	logic FLASH_SELECT_N, FLASH_WRITE_N, ROM_CHIP_SELECT;
	int n_mismatch, cmp_count, n, i;
	wire logic FLASH_ADDR14_OR_ROM_SERIAL_IN_IN = FLASH_ADDR14_OR_ROM_SERIAL_IN_OE ?
		FLASH_ADDR14_OR_ROM_SERIAL_IN_OUT : rom_so;
	wire logic CLOCK_OUT_STRAP_IN = CLOCK_OUT_STRAP_OE ? CLOCK_OUT_STRAP_OUT : strap_up;
	// idle flash bus reads as the inverse so a stale capture shows
	wire logic [7:0] FLASH_DATA_BUS_IN = (&FLASH_DATA_BUS_OE) ? FLASH_DATA_BUS_OUT :
		(FLASH_SELECT_N ? 8'hc3 : 8'h3c);
	sys_pm_pin_control #(.WAKE_PULSE_CYCLES(WAKE)) uut (.*);
	rom_model #(.WORD(ROM_WORD)) mdl (.cs(ROM_CHIP_SELECT), .sk(FLASH_ADDR15_OR_ROM_CLOCK),
		.si(FLASH_ADDR13_OR_ROM_SERIAL_OUT), .so(rom_so), .rx(rom_rx));
	////////////////////////////////////////////////////////////////
	task give_verdict;
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [16:0] e, input logic [16:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task cyc(input int c);
		repeat (c) @(negedge REF_CLK);
	endtask
	task wdone(input bit fl);
		for (int k = 0; k < 6000; k++) begin
			@(negedge REF_CLK);
			if (fl ? FLASH_DONE : ROM_DONE) return;
		end
		chk("done wait", 1'b1, 1'b0);
		give_verdict;
	endtask
	////////////////////////////////////////////////////////////////
	task t_bus;
		HOST_OUT_D = 8'h96; HOST_OUT_EN = 8'hff; HOST_PIN_IN = 8'h5a; cyc(2);
		chk("pin_oe", 8'hff, HOST_PIN_OE);
		chk("pin_out", 8'h96, HOST_PIN_OUT);
		BUS_RESET_N = 0; cyc(2);
		chk("pin_oe", 8'h00, HOST_PIN_OE);
		chk("in_q", 8'h00, HOST_IN_Q);
		BUS_RESET_N = 1; HOST_PIN_IN = 8'h3c; cyc(2);
		// detach driven from bus reset, so both fall together
		DETACH_N = 0; BUS_RESET_N = 0;
		HOST_PIN_IN = 8'ha5; PM_EVENT_SET = 1; cyc(1); PM_EVENT_SET = 0; cyc(1);
		chk("pin_oe", 8'h00, HOST_PIN_OE);
		chk("in_q", 8'h3c, HOST_IN_Q);
		chk("event_oe", 1'b1, PM_EVENT_N_OE);
		chk("event_out", 1'b0, PM_EVENT_N_OUT);
		PM_EVENT_CLEAR = 1; cyc(1); PM_EVENT_CLEAR = 0; DETACH_N = 1; BUS_RESET_N = 1;
		chk("event_oe", 1'b0, PM_EVENT_N_OE);
	endtask
	task t_pause;
		CLOCK_NEEDED = 1; CLOCK_PAUSE_IN = 1; cyc(1); CLOCK_PAUSE_IN = 0;
		chk("pause_oe", 1'b1, CLOCK_PAUSE_OE);
		chk("pause_out", 1'b0, CLOCK_PAUSE_OUT);
		cyc(2); chk("pause_oe", 1'b0, CLOCK_PAUSE_OE);
		CLOCK_NEEDED = 0; CLOCK_PAUSE_IN = 1; cyc(2);
		chk("stop_ok", 1'b1, CLOCK_STOP_OK);
		chk("pause_oe", 1'b0, CLOCK_PAUSE_OE);
		CLOCK_PAUSE_IN = 0;
	endtask
	task t_flash;
		FLASH_ADDR = 17'h1a5c3; FLASH_WRITE = 1; FLASH_WDATA = 8'h69;
		FLASH_REQ = 1; cyc(1); FLASH_REQ = 0; cyc(3);
		chk("sel_n", 1'b0, FLASH_SELECT_N);
		chk("data_oe", 8'hff, FLASH_DATA_BUS_OE);
		chk("data_out", 8'h69, FLASH_DATA_BUS_OUT);
		chk("we_n", 1'b0, FLASH_WRITE_N);
		chk("a16", FLASH_ADDR[16], FLASH_ADDR16_OR_CLOCK_OUT);
		chk("a15", FLASH_ADDR[15], FLASH_ADDR15_OR_ROM_CLOCK);
		chk("a14", {1'b1, FLASH_ADDR[14]}, {FLASH_ADDR14_OR_ROM_SERIAL_IN_OE,
			FLASH_ADDR14_OR_ROM_SERIAL_IN_OUT});
		chk("a13", FLASH_ADDR[13], FLASH_ADDR13_OR_ROM_SERIAL_OUT);
		chk("a7", FLASH_ADDR[7], CLOCK_OUT_STRAP_OUT);
		chk("rest", {FLASH_ADDR[12:8], FLASH_ADDR[6:0]}, FLASH_ADDR_REST);
		wdone(1); cyc(1); FLASH_WRITE = 0; FLASH_REQ = 1; cyc(1); FLASH_REQ = 0; cyc(3);
		chk("data_oe", 8'h00, FLASH_DATA_BUS_OE);
		chk("we_n", 1'b1, FLASH_WRITE_N);
		wdone(1); chk("rdata", 8'h3c, FLASH_RDATA);
	endtask
	task t_rom;
		ROM_TX = 16'hb6d1; ROM_LEN = 5'h10; cyc(1); ROM_REQ = 1; cyc(1); ROM_REQ = 0; cyc(300);
		chk("rom_cs", 1'b1, ROM_CHIP_SELECT);
		chk("a14_oe", 1'b0, FLASH_ADDR14_OR_ROM_SERIAL_IN_OE);
		chk("mem_busy", 1'b1, MEM_BUSY);
		FLASH_REQ = 1; cyc(1); FLASH_REQ = 0; cyc(3);
		chk("sel_n", 1'b1, FLASH_SELECT_N);
		wdone(0); chk("rom_rdata", ROM_WORD, ROM_RDATA);
		chk("rom_rx", ROM_TX, rom_rx);
		cyc(1); chk("rom_cs", 1'b0, ROM_CHIP_SELECT);
		ROM_TX = 16'h4e2b; ROM_LEN = 5'h05; ROM_REQ = 1; cyc(1); ROM_REQ = 0;
		wdone(0); chk("rom_rdata", {ROM_TX[10:0], ROM_WORD[15:11]}, ROM_RDATA);
	endtask
	task t_wake;
		cyc(1); WAKE_FRAME_SEEN = 1; cyc(1); WAKE_FRAME_SEEN = 0; n = 0;
		for (i = 0; i < 40; i++) begin
			if (CARD_STATUS_CHANGE_OR_WAKE_PULSE === 1'b1) n++;
			cyc(1);
		end
		chk("wake_len", 17'(WAKE), n[16:0]);
		CARDBUS_MODE = 1; PM_EVENT_SET = 1; cyc(1); PM_EVENT_SET = 0; cyc(1);
		chk("card_status", 1'b1, CARD_STATUS_CHANGE_OR_WAKE_PULSE);
		PM_EVENT_CLEAR = 1; cyc(1); PM_EVENT_CLEAR = 0; cyc(1);
		chk("card_status", 1'b0, CARD_STATUS_CHANGE_OR_WAKE_PULSE);
		CARDBUS_MODE = 0;
	endtask
	task t_strap;
		strap_up = 1; POWER_UP_RESET_N = 0; cyc(2);
		chk("strap_oe", 1'b0, CLOCK_OUT_STRAP_OE);
		chk("bus_in_reset", 1'b1, BUS_IN_RESET);
		POWER_UP_RESET_N = 1; cyc(2); n = 0;
		chk("strap_oe", 1'b1, CLOCK_OUT_STRAP_OE);
		for (i = 0; i < 20; i++) begin
			if (FLASH_ADDR16_OR_CLOCK_OUT === 1'b1) n++;
			cyc(1);
		end
		chk("clk25_high", 17'h8, n[16:0]);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		REF_CLK = 0;
		forever #4 REF_CLK = ~REF_CLK;
	end
	initial begin
		{CLOCK_PAUSE_IN, CLOCK_NEEDED, CARDBUS_MODE, PM_EVENT_SET, PM_EVENT_CLEAR, WAKE_FRAME_SEEN,
			FLASH_REQ, FLASH_WRITE, ROM_REQ, HOST_OUT_D, HOST_OUT_EN, HOST_PIN_IN, FLASH_WDATA,
			FLASH_ADDR, ROM_TX, ROM_LEN, strap_up} = '0;
		RST = 1; POWER_UP_RESET_N = 1; BUS_RESET_N = 1; DETACH_N = 1;
		n_mismatch = 0; cmp_count = 0;
		cyc(10); RST = 0; cyc(1);
		chk("sel_n", 1'b1, FLASH_SELECT_N);
		t_bus; t_pause; t_flash; t_rom; t_wake; t_strap;
		give_verdict;
	end
endmodule // sys_pm_pin_control_tb
`default_nettype wire
